// File: testbench/amcr_top_bench.sv
// self-checking bench for the converter control block
// drives APB, triggers and analog result; 50 MHz clock
`timescale 1ns/1ps
module amcr_top_bench;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, doneVectorAck;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:1] triggerIn;
  logic [9:0] analogResult;
  logic converterOn, converting, refExternalPin, refAnalogSupply, refInternal1v1, refInternal2v56;
  logic differential, bandgapSelect, groundSelect, doneIrq, err;
  logic [1:0] activeRefSelect;
  logic [2:0] posInput, negInput;
  amcr_pkg::amcr_gain_t gainSelect;
  int n_mismatch, checked, cycles;
  amcr_top amcr_top_inst (.*);
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end
  task conclude();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // one APB transfer; request held until pready sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // ends when pready is sampled high; if pready never rises only the bench timeout ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task waitConv(input logic v, output int n);
    n = 0;
    while (converting !== v) begin
      @(posedge clk);
      n++;
    end
  endtask
  task runConv(input logic [7:0] c, input int cyc);
    int n;
    apb(1, amcr_pkg::ADDR_CTRL_A, {24'h0, c});
    waitConv(1, n);
    waitConv(0, n);
    chk(32'(n >= cyc - 3 && n <= cyc + 3), 1, "conversion length");
  endtask
  task testRegs();
    apb(0, amcr_pkg::ADDR_CTRL_A, 0);
    chk(rd, 0, "ctrl A reset");
    apb(0, amcr_pkg::ADDR_MUX, 0);
    chk(rd, 0, "mux reset");
    apb(1, amcr_pkg::ADDR_MUX, 32'hff);
    apb(0, amcr_pkg::ADDR_MUX, 0);
    chk(rd, 32'hff, "mux rw");
    apb(1, amcr_pkg::ADDR_CTRL_A, 32'h2f);
    apb(0, amcr_pkg::ADDR_CTRL_A, 0);
    chk(rd, 32'h2f, "ctrl A rw");
    apb(0, 12'h004, 0);
    chk(32'(err), 1, "unmapped");
    apb(1, amcr_pkg::ADDR_CTRL_A, 0);
    $display("regs done");
  endtask
  task testDecode();
    logic [4:0] c;
    logic [1:0] r;
    for (int i = 0; i < 32; i++) begin
      c = 5'(i);
      r = (i >= 8 && i < 16) ? 2'h3 : c[1:0];
      apb(1, amcr_pkg::ADDR_MUX, {24'h0, r, 1'b0, c});
      repeat (3) @(posedge clk);
      chk(32'({refInternal2v56, refInternal1v1, refAnalogSupply, refExternalPin}), 32'h1 << r, "ref");
      chk(32'({differential, bandgapSelect, groundSelect}), 32'({i >= 8 && i < 30, i == 30, i == 31}), "kind");
      if (i < 8 || (i >= 16 && i < 30)) chk(32'(posInput), 32'(c[2:0]), "pos");
      if (i >= 8 && i < 16) chk(32'({posInput, negInput, gainSelect}), 32'({1'b0, c[2], c[0], 1'b0, c[2], 1'b0,
        c[1] ? 2'h2 : 2'h1}), "gain pair");
      if (i >= 16 && i < 30) chk(32'({negInput, gainSelect}), 32'({i < 24 ? 3'h1 : 3'h2, 2'h0}), "unity");
    end
    apb(1, amcr_pkg::ADDR_MUX, 0);
    $display("decode done");
  endtask
  task testSingle();
    int n;
    analogResult <= 10'h270;
    runConv(8'hc0, 50);
    apb(0, amcr_pkg::ADDR_CTRL_A, 0);
    chk(rd, 32'h90, "start clear, done set");
    apb(0, amcr_pkg::ADDR_RESULT, 0);
    chk(rd, 32'h270, "right adjust");
    apb(1, amcr_pkg::ADDR_MUX, 32'h20);
    apb(0, amcr_pkg::ADDR_RESULT, 0);
    chk(rd, 32'h9c00, "left adjust");
    apb(1, amcr_pkg::ADDR_CTRL_A, 32'hd2);
    apb(0, amcr_pkg::ADDR_CTRL_A, 0);
    chk(rd, 32'hc2, "start live, done cleared");
    apb(1, amcr_pkg::ADDR_MUX, 32'hc5);
    apb(1, amcr_pkg::ADDR_CTRL_A, 32'h82);
    chk(32'({converting, activeRefSelect}), 32'h4, "old ref kept");
    apb(0, amcr_pkg::ADDR_RESULT, 0);
    chk(rd, 32'h270, "adjust mid conversion");
    waitConv(0, n);
    repeat (3) @(posedge clk);
    chk(32'(activeRefSelect), 3, "new ref applied");
    apb(1, amcr_pkg::ADDR_CTRL_A, 32'hd0);
    repeat (10) @(posedge clk);
    apb(1, amcr_pkg::ADDR_CTRL_A, 0);
    apb(0, amcr_pkg::ADDR_CTRL_A, 0);
    chk(32'({converting, converterOn, rd[7:0]}), 0, "abort");
    $display("single done");
  endtask
  task testPrescale();
    for (int p = 0; p < 8; p++) begin
      apb(1, amcr_pkg::ADDR_CTRL_A, 0);
      runConv({5'h1b, 3'(p)}, 25 * (p == 0 ? 2 : 1 << p));
      repeat (2) @(posedge clk);
      chk(32'(doneIrq), 1, "done irq");
      doneVectorAck <= 1;
      @(posedge clk);
      doneVectorAck <= 0;
      repeat (3) @(posedge clk);
      chk(32'(doneIrq), 0, "vector clear");
    end
    runConv(8'hda, 52);
    $display("prescale done");
  endtask
  task testAuto();
    int n;
    apb(1, amcr_pkg::ADDR_CTRL_A, 0);
    apb(1, amcr_pkg::ADDR_CTRL_B, 1);
    apb(1, amcr_pkg::ADDR_CTRL_A, 32'ha0);
    triggerIn <= 7'h1;
    repeat (8) @(posedge clk);
    chk(32'(converting), 1, "trigger edge");
    triggerIn <= 0;
    waitConv(0, n);
    apb(1, amcr_pkg::ADDR_CTRL_B, 0);
    apb(1, amcr_pkg::ADDR_CTRL_A, 32'hf0);
    // first free-run conversion takes 26 clocks; read inside the second one
    repeat (40) @(posedge clk);
    apb(0, amcr_pkg::ADDR_CTRL_A, 0);
    chk(rd, 32'hf0, "free run restart");
    apb(1, amcr_pkg::ADDR_CTRL_A, 0);
    $display("auto done");
  endtask
  initial begin
    rst_n = 0;
    {psel, penable, pwrite, doneVectorAck} = 0;
    paddr = 0;
    pwdata = 0;
    triggerIn = 0;
    analogResult = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    testRegs();
    testDecode();
    testSingle();
    testPrescale();
    testAuto();
    conclude();
  end
endmodule

// File: testbench/amcr_top_properties.sv
// port assertions for the converter control block
// bound into amcr_top; single clock, async active-low reset
`timescale 1ns/1ps
module amcr_top_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic doneVectorAck,
  input wire logic converterOn,
  input wire logic converting,
  input wire logic [1:0] activeRefSelect,
  input wire logic refExternalPin,
  input wire logic refAnalogSupply,
  input wire logic refInternal1v1,
  input wire logic refInternal2v56,
  input wire logic differential,
  input wire amcr_pkg::amcr_gain_t gainSelect,
  input wire logic bandgapSelect,
  input wire logic groundSelect,
  input wire logic doneIrq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence ctrlWr;
    psel && penable && pready && pwrite && paddr == amcr_pkg::ADDR_CTRL_A;
  endsequence
  sequence convRun;
    (converting || !converterOn) [*8];
  endsequence
  a_start_launch: assert property (ctrlWr ##0 (pwdata[7:6] == 2'h3 && !converting) |=> converting)
    else $error("start write did not launch a conversion");
  a_start_zero: assert property (ctrlWr ##0 (pwdata[7:6] == 2'h2 && converting) |=> converting)
    else $error("start write of zero disturbed a conversion");
  a_enable_abort: assert property (ctrlWr ##0 !pwdata[7] |=> !converterOn ##1 !converting)
    else $error("disable did not abort");
  a_enable_on: assert property (ctrlWr ##0 pwdata[7] |=> converterOn)
    else $error("enable write ignored");
  a_conv_min: assert property ($rose(converting) |-> convRun)
    else $error("conversion ended too soon");
  a_ref_frozen: assert property (converting && $past(converting) |-> $stable(activeRefSelect))
    else $error("reference changed mid conversion");
  a_ref_decode: assert property ($past(rst_n, 2) |->
    {refInternal2v56, refInternal1v1, refAnalogSupply, refExternalPin} == 4'h1 << $past(activeRefSelect))
    else $error("reference decode wrong");
  a_gain_diff: assert property (gainSelect != amcr_pkg::GAIN_1X |-> differential)
    else $error("gain without differential pair");
  a_bandgap_only: assert property (bandgapSelect |-> !groundSelect && !differential)
    else $error("bandgap mixed with other input");
  a_done_ack: assert property (doneVectorAck && !converting |-> ##2 !doneIrq)
    else $error("vector entry did not clear done");
endmodule
bind amcr_top amcr_top_properties amcr_top_properties_inst (.*);

// File: verilog/amcr_pkg.sv
// register map, field positions, reset values and cycle counts of the converter control block
// assumes a 32-bit APB master with 12-bit byte addresses; one register per aligned word, 8 bits wide except the 16-bit result
package amcr_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_RESULT = 8'h78;
  localparam logic [7:0] IDX_CTRL_A = 8'h7a;
  localparam logic [7:0] IDX_CTRL_B = 8'h7b;
  localparam logic [7:0] IDX_MUX = 8'h7c;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] ADDR_RESULT = {2'h0, IDX_RESULT, 2'h0};
  localparam logic [11:0] ADDR_CTRL_A = {2'h0, IDX_CTRL_A, 2'h0};
  localparam logic [11:0] ADDR_CTRL_B = {2'h0, IDX_CTRL_B, 2'h0};
  localparam logic [11:0] ADDR_MUX = {2'h0, IDX_MUX, 2'h0};

  // input_mux_select fields
  localparam int unsigned MUX_REF_LSB = 6;
  localparam int unsigned MUX_LEFT_ADJ = 5;
  localparam int unsigned MUX_CHAN_LSB = 0;
  localparam logic [7:0] MUX_RESET = 8'h00;

  // converter_control_a fields
  localparam int unsigned CA_ENABLE = 7;
  localparam int unsigned CA_START = 6;
  localparam int unsigned CA_AUTO = 5;
  localparam int unsigned CA_DONE = 4;
  localparam int unsigned CA_IE = 3;
  localparam int unsigned CA_PS_LSB = 0;
  localparam logic [7:0] CA_RESET = 8'h00;

  // converter_control_b: trigger source in the low three bits
  localparam logic [2:0] TRIG_RESET = 3'h0;
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

  localparam int unsigned RESULT_W = 10;
  localparam logic [4:0] FIRST_CONV_CYCLES = 5'd25;
  localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd13;

  typedef enum logic [1:0] {GAIN_1X, GAIN_10X, GAIN_200X} amcr_gain_t;
  typedef enum logic {ST_IDLE, ST_CONVERT} amcr_state_t;

  // converter clock division for each prescale code
  function automatic logic [7:0] prescaleDivisor(input logic [2:0] sel);
    logic [7:0] div;
    div = 8'h01 << sel;
    if (sel == 3'h0) begin
      div = 8'h02;
    end
    return div;
  endfunction

endpackage

// File: verilog/amcr_prescaler.sv
// converter clock generator: one-cycle tick every N system clocks
// assumes sel only matters while run is high; counter restarts when run drops
`timescale 1ns/1ps
module amcr_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);

  logic [7:0] count_q;
  logic [7:0] lastCount;

  assign lastCount = amcr_pkg::prescaleDivisor(sel) - 8'h01;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 8'h00;
    end else if (!run || count_q >= lastCount) begin
      // >= so a smaller divisor chosen mid-count cannot overrun
      count_q <= 8'h00;
    end else begin
      count_q <= count_q + 8'h01;
    end
  end

  assign tick = run && (count_q >= lastCount);

endmodule

// File: verilog/amcr_top.sv
// converter control block: input mux select, control A/B and result register behind APB
// assumes the analog core presents a steady 10-bit result by the last converter clock of a conversion
//
// Summary of operation
// - reference and channel settings written mid-conversion apply only after that conversion ends.
// - reference code selects external pin, analog supply, internal 1.1V or 2.56V.
// - left-adjust bit set left-justifies result in 16 bits, else right-justifies.
// - changing left-adjust alters the presented result immediately, even mid-conversion.
// - channel codes 0 to 7 select single-ended inputs 0 to 7.
// - codes 8 to 15 select gain pairs against input 0 or 2, 10x or 200x.
// - codes 16-23 pair against input 1, 24-29 against input 2, unity gain.
// - code 30 selects the 1.1V bandgap, code 31 selects ground.
// - mux register holds reference 7:6, left-adjust 5, channel 4:0, reset zero.
// - control A holds enable, start, auto, done, interrupt enable, prescale; reset zero.
// - writing enable one powers the converter on, zero powers it off.
// - clearing enable during a conversion aborts it.
// - in single mode a start write of one while idle, with enable set or set in the same write, launches exactly one conversion.
// - in free-running mode one start write begins endless back-to-back conversions.
// - first conversion after enabling takes 25 converter clocks, later ones 13.
// - start bit reads one while converting and zero once complete.
// - writing zero to start is ignored.
// - with auto-trigger on, a rising edge of the selected trigger starts a conversion.
// - done flag sets on completion; cleared by writing one or vector acknowledge.
// - prescale codes divide system clock by 2,2,4,8,16,32,64,128.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module amcr_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:1] triggerIn,
  input wire logic [9:0] analogResult,
  input wire logic doneVectorAck,
  output logic converterOn,
  output logic converting,
  output logic [1:0] activeRefSelect,
  output logic refExternalPin,
  output logic refAnalogSupply,
  output logic refInternal1v1,
  output logic refInternal2v56,
  output logic [2:0] posInput,
  output logic [2:0] negInput,
  output logic differential,
  output amcr_pkg::amcr_gain_t gainSelect,
  output logic bandgapSelect,
  output logic groundSelect,
  output logic doneIrq
);

  // register storage
  logic [1:0] refSel_q;
  logic leftAdjust_q;
  logic [4:0] chanSel_q;
  logic enable_q;
  logic autoTrig_q;
  logic doneFlag_q;
  logic doneIe_q;
  logic [2:0] prescale_q;
  logic [2:0] trigSrc_q;
  logic [9:0] result_q;

  // bus outputs
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // conversion engine
  amcr_pkg::amcr_state_t state_q;
  logic [4:0] cycle_q;
  logic firstPending_q;
  logic [4:0] convLen_q;

  // synchronisers
  logic [7:1] trigMeta_q;
  logic [7:1] trigSync_q;
  logic trigPrev_q;
  logic [9:0] resMeta_q;
  logic [9:0] resSync_q;

  // analog-facing registered outputs
  logic [1:0] actRef_q;
  logic [4:0] actChan_q;
  logic refExt_q;
  logic refAvcc_q;
  logic ref1v1_q;
  logic ref2v56_q;
  logic [2:0] posIn_q;
  logic [2:0] negIn_q;
  logic diff_q;
  amcr_pkg::amcr_gain_t gain_q;
  logic bandgap_q;
  logic ground_q;
  logic doneIrq_q;

  logic adcTick;
  logic setupPhase;
  logic wrAccess;
  logic wrCtrlA;
  logic wrMux;
  logic wrCtrlB;
  logic startWrite;
  logic enableWrite;
  logic trigSelected;
  logic trigEvent;
  logic convDone;
  logic freeRun;
  logic launch;
  logic [15:0] presented;
  logic [7:0] ctrlARead;

  // positive input of a channel code; unused for bandgap and ground codes
  function automatic logic [2:0] chanPositive(input logic [4:0] code);
    logic [2:0] pos;
    pos = code[2:0];
    if (code[4:3] == 2'b01) begin
      pos = {1'b0, code[2], code[0]};
    end
    return pos;
  endfunction

  // negative input of a differential code
  function automatic logic [2:0] chanNegative(input logic [4:0] code);
    logic [2:0] neg;
    neg = 3'h0;
    case (code[4:3])
      2'b01: neg = {1'b0, code[2], 1'b0};
      2'b10: neg = 3'h1;
      2'b11: neg = 3'h2;
      default: neg = 3'h0;
    endcase
    return neg;
  endfunction

  function automatic amcr_pkg::amcr_gain_t chanGain(input logic [4:0] code);
    amcr_pkg::amcr_gain_t g;
    g = amcr_pkg::GAIN_1X;
    if (code[4:3] == 2'b01) begin
      g = code[1] ? amcr_pkg::GAIN_200X : amcr_pkg::GAIN_10X;
    end
    return g;
  endfunction

  amcr_prescaler u_prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .run(enable_q),
    .sel(prescale_q),
    .tick(adcTick)
  );

  // bus decode
  assign setupPhase = psel && !penable;
  assign wrAccess = psel && penable && pready_q && pwrite;
  assign wrCtrlA = wrAccess && (paddr == amcr_pkg::ADDR_CTRL_A);
  assign wrCtrlB = wrAccess && (paddr == amcr_pkg::ADDR_CTRL_B);
  assign wrMux = wrAccess && (paddr == amcr_pkg::ADDR_MUX);
  assign enableWrite = wrCtrlA && pwdata[amcr_pkg::CA_ENABLE];
  assign startWrite = wrCtrlA && pwdata[amcr_pkg::CA_START];

  // result presentation follows the live left-adjust bit
  assign presented = leftAdjust_q ? {result_q, 6'h00} : {6'h00, result_q};

  assign ctrlARead = {enable_q, (state_q == amcr_pkg::ST_CONVERT), autoTrig_q, doneFlag_q,
                      doneIe_q, prescale_q};

  // trigger selection and edge detection on synchronised inputs
  assign freeRun = autoTrig_q && (trigSrc_q == amcr_pkg::TRIG_FREE_RUN);
  assign trigSelected = (trigSrc_q == amcr_pkg::TRIG_FREE_RUN) ? 1'b0 : trigSync_q[trigSrc_q];
  assign trigEvent = autoTrig_q && trigSelected && !trigPrev_q;

  assign convDone = (state_q == amcr_pkg::ST_CONVERT) && enable_q && adcTick
                    && (cycle_q == convLen_q - 5'd1);
  // enable may arrive in the same write as start
  assign launch = (state_q == amcr_pkg::ST_IDLE) && (enable_q || enableWrite)
                  && (startWrite || trigEvent) && !(wrCtrlA && !pwdata[amcr_pkg::CA_ENABLE]);

  // APB answer: data and pready prepared in setup, one-cycle access phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (setupPhase) begin
      pready_q <= 1'b1;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      case (paddr)
        amcr_pkg::ADDR_RESULT: prdata_q <= {16'h0000, presented};
        amcr_pkg::ADDR_CTRL_A: prdata_q <= {24'h000000, ctrlARead};
        amcr_pkg::ADDR_CTRL_B: prdata_q <= {29'h0, trigSrc_q};
        amcr_pkg::ADDR_MUX: prdata_q <= {24'h000000, refSel_q, leftAdjust_q, chanSel_q};
        default: pslverr_q <= 1'b1;
      endcase
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // input_mux_select storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {refSel_q, leftAdjust_q, chanSel_q} <= amcr_pkg::MUX_RESET;
    end else if (wrMux) begin
      refSel_q <= pwdata[amcr_pkg::MUX_REF_LSB +: 2];
      leftAdjust_q <= pwdata[amcr_pkg::MUX_LEFT_ADJ];
      chanSel_q <= pwdata[amcr_pkg::MUX_CHAN_LSB +: 5];
    end
  end

  // converter_control_a stored bits and control B
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {enable_q, autoTrig_q, doneIe_q, prescale_q} <= {amcr_pkg::CA_RESET[7], amcr_pkg::CA_RESET[5],
                                                      amcr_pkg::CA_RESET[3:0]};
      trigSrc_q <= amcr_pkg::TRIG_RESET;
    end else begin
      if (wrCtrlA) begin
        enable_q <= pwdata[amcr_pkg::CA_ENABLE];
        autoTrig_q <= pwdata[amcr_pkg::CA_AUTO];
        doneIe_q <= pwdata[amcr_pkg::CA_IE];
        prescale_q <= pwdata[amcr_pkg::CA_PS_LSB +: 3];
      end
      if (wrCtrlB) begin
        trigSrc_q <= pwdata[2:0];
      end
    end
  end

  // done flag: completion beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      doneFlag_q <= 1'b0;
    end else if (convDone) begin
      doneFlag_q <= 1'b1;
    end else if ((wrCtrlA && pwdata[amcr_pkg::CA_DONE]) || doneVectorAck) begin
      doneFlag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      doneIrq_q <= 1'b0;
    end else begin
      doneIrq_q <= doneFlag_q && doneIe_q;
    end
  end

  // pin synchronisers; only the second stage is looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigMeta_q <= 7'h00;
      trigSync_q <= 7'h00;
      resMeta_q <= 10'h000;
      resSync_q <= 10'h000;
      trigPrev_q <= 1'b0;
    end else begin
      trigMeta_q <= triggerIn;
      trigSync_q <= trigMeta_q;
      resMeta_q <= analogResult;
      resSync_q <= resMeta_q;
      // previous value of the selected line, so switching to a high source is an edge
      trigPrev_q <= trigSelected;
    end
  end

  // first-conversion marker, armed by each off-to-on transition that does not launch in the same write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      firstPending_q <= 1'b0;
    end else if (!enable_q && enableWrite && !launch) begin
      firstPending_q <= 1'b1;
    end else if (launch || !enable_q) begin
      firstPending_q <= 1'b0;
    end
  end

  // conversion sequencer counted in converter clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= amcr_pkg::ST_IDLE;
      cycle_q <= 5'd0;
      convLen_q <= amcr_pkg::NORMAL_CONV_CYCLES;
      result_q <= 10'h000;
    end else begin
      case (state_q)
        amcr_pkg::ST_IDLE: begin
          cycle_q <= 5'd0;
          if (launch) begin
            state_q <= amcr_pkg::ST_CONVERT;
            convLen_q <= (firstPending_q || !enable_q) ? amcr_pkg::FIRST_CONV_CYCLES
                                                       : amcr_pkg::NORMAL_CONV_CYCLES;
          end
        end
        amcr_pkg::ST_CONVERT: begin
          if (!enable_q) begin
            state_q <= amcr_pkg::ST_IDLE;
            cycle_q <= 5'd0;
          end else if (convDone) begin
            result_q <= resSync_q;
            cycle_q <= 5'd0;
            convLen_q <= amcr_pkg::NORMAL_CONV_CYCLES;
            // free-running restarts at once without software
            state_q <= freeRun ? amcr_pkg::ST_CONVERT : amcr_pkg::ST_IDLE;
          end else if (adcTick) begin
            cycle_q <= cycle_q + 5'd1;
          end
        end
        default: state_q <= amcr_pkg::ST_IDLE;
      endcase
    end
  end

  // settings reach the analog side only between conversions
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      actRef_q <= 2'h0;
      actChan_q <= 5'h00;
    end else if (state_q == amcr_pkg::ST_IDLE || convDone) begin
      actRef_q <= refSel_q;
      actChan_q <= chanSel_q;
    end
  end

  // decoded analog selects, registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refExt_q <= 1'b0;
      refAvcc_q <= 1'b0;
      ref1v1_q <= 1'b0;
      ref2v56_q <= 1'b0;
      posIn_q <= 3'h0;
      negIn_q <= 3'h0;
      diff_q <= 1'b0;
      gain_q <= amcr_pkg::GAIN_1X;
      bandgap_q <= 1'b0;
      ground_q <= 1'b0;
    end else begin
      refExt_q <= (actRef_q == 2'b00);
      refAvcc_q <= (actRef_q == 2'b01);
      ref1v1_q <= (actRef_q == 2'b10);
      ref2v56_q <= (actRef_q == 2'b11);
      posIn_q <= chanPositive(actChan_q);
      negIn_q <= chanNegative(actChan_q);
      diff_q <= (actChan_q[4:3] != 2'b00) && (actChan_q[4:1] != 4'hf);
      gain_q <= chanGain(actChan_q);
      bandgap_q <= (actChan_q == 5'h1e);
      ground_q <= (actChan_q == 5'h1f);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign converterOn = enable_q;
  assign converting = (state_q == amcr_pkg::ST_CONVERT);
  assign activeRefSelect = actRef_q;
  assign refExternalPin = refExt_q;
  assign refAnalogSupply = refAvcc_q;
  assign refInternal1v1 = ref1v1_q;
  assign refInternal2v56 = ref2v56_q;
  assign posInput = posIn_q;
  assign negInput = negIn_q;
  assign differential = diff_q;
  assign gainSelect = gain_q;
  assign bandgapSelect = bandgap_q;
  assign groundSelect = ground_q;
  assign doneIrq = doneIrq_q;

endmodule
